// [swsu_pkg.sv]
package swsu_pkg;
	// ****************************************************
	// register byte offsets
	// ****************************************************
	localparam logic [7:0] SWSU_OFF_TX_DATA = 8'h00;
	localparam logic [7:0] SWSU_OFF_RX_DATA = 8'h04;
	localparam logic [7:0] SWSU_OFF_LINE_FORMAT = 8'h08;
	localparam logic [7:0] SWSU_OFF_LINE_STATUS = 8'h0C;
	localparam logic [7:0] SWSU_OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] SWSU_OFF_TXQ_STATUS = 8'h14;
	localparam logic [7:0] SWSU_OFF_TXQ_CONTROL = 8'h18;
	localparam logic [7:0] SWSU_OFF_RXQ_STATUS = 8'h1C;
	localparam logic [7:0] SWSU_OFF_RXQ_CONTROL = 8'h20;
	localparam logic [7:0] SWSU_OFF_IDLE_LOWER = 8'h24;
	localparam logic [7:0] SWSU_OFF_IDLE_UPPER = 8'h28;
	localparam logic [7:0] SWSU_OFF_DIV_LOWER = 8'h2C;
	localparam logic [7:0] SWSU_OFF_DIV_UPPER = 8'h30;
	localparam logic [7:0] SWSU_OFF_MODE = 8'h34;
	// ****************************************************
	// field positions
	// ****************************************************
	localparam int SWSU_FMT_STOP2 = 5;
	localparam int SWSU_FMT_ECHO = 6;
	localparam int SWSU_ST_TX_RDY = 0;
	localparam int SWSU_ST_RX_RDY = 1;
	localparam int SWSU_ST_TX_DONE = 2;
	localparam int SWSU_ST_OVR = 3;
	localparam int SWSU_ST_FER = 4;
	localparam int SWSU_ST_PER = 5;
	localparam int SWSU_ST_BRK = 6;
	localparam int SWSU_QC_FLUSH = 7;
	// ****************************************************
	// reset values and constants
	// ****************************************************
	localparam logic [6:0] SWSU_FORMAT_RST = 7'h03;
	localparam logic [15:0] SWSU_DIV_RST = 16'h0000;
	localparam logic [15:0] SWSU_DEBUG_MAX_DIV = 16'h0030;
	localparam logic [4:0] SWSU_QUEUE_DEPTH = 5'h10;
	localparam logic [2:0] SWSU_TRAIN_FALLS = 3'h5;
	localparam logic [31:0] SWSU_UNMAPPED_READ = 32'h00000000;
	typedef enum logic [5:0] {
		SWSU_RX_IDLE = 6'h01,
		SWSU_RX_START = 6'h02,
		SWSU_RX_DATA = 6'h04,
		SWSU_RX_PAR = 6'h08,
		SWSU_RX_STOP = 6'h10,
		SWSU_RX_WAIT_HIGH = 6'h20
	} swsu_rx_t;
	typedef enum logic [4:0] {
		SWSU_TX_IDLE = 5'h01,
		SWSU_TX_START = 5'h02,
		SWSU_TX_DATA = 5'h04,
		SWSU_TX_PAR = 5'h08,
		SWSU_TX_STOP = 5'h10
	} swsu_tx_t;
endpackage : swsu_pkg

// [swsu_unit.sv]
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module swsu_unit
	import swsu_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output var logic [31:0] AVS_READDATA,
	output var logic AVS_WAITREQUEST,
	input wire logic SWIO_IN,
	output var logic SWIO_OUT,
	output var logic SWIO_OE,
	output var logic IRQ
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic sync1;
		logic sync2;
		logic [2:0] filt;
		logic line;
		logic [6:0] format;
		logic [6:0] irq_en;
		logic [3:0] tx_level;
		logic [3:0] rx_level;
		logic [15:0] idle_limit;
		logic [7:0] idle_low;
		logic [15:0] divisor;
		logic [7:0] div_low;
		logic trained;
		logic debug_mode;
		logic [2:0] falls;
		logic [15:0] train_cnt;
		logic [7:0] tx_window;
		logic [15:0][7:0] txq;
		logic [3:0] txq_rd;
		logic [3:0] txq_wr;
		logic [4:0] txq_cnt;
		logic [15:0][7:0] rxq;
		logic [3:0] rxq_rd;
		logic [3:0] rxq_wr;
		logic [4:0] rxq_cnt;
		swsu_tx_t tx_state;
		logic [15:0] tx_timer;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_line;
		logic tx_oe;
		swsu_rx_t rx_state;
		logic [15:0] rx_timer;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic tx_done;
		logic ovr;
		logic fer;
		logic per;
		logic [15:0] tick_cnt;
		logic [16:0] idle_cnt;
		logic forced;
		logic irq;
	} swsu_state_t;

	swsu_state_t st;
	swsu_state_t next_st;

	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic swsu_par(input logic [2:0] mode,
		input logic [7:0] d);
		logic p;
		p = 1'b0;
		case (mode)
			3'h1: p = ~^d;
			3'h3: p = ^d;
			3'h5: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction : swsu_par

	logic [7:0] len_mask;
	logic [2:0] last_bit;
	logic par_on;
	logic run;
	logic bit_tick;
	logic tx_rdy;
	logic rx_rdy;
	logic rx_push;
	logic [7:0] rx_data;
	logic txq_pop;
	logic txq_push;
	logic rxq_pop;
	logic [6:0] status;
	logic req;
	logic wr;
	logic rd;
	logic fall;
	logic per_set;
	logic fer_set;

	always_comb begin
		next_st = st;
		// length select sets mask and last bit
		last_bit = 3'h4 + {1'b0, st.format[1:0]};
		len_mask = 8'hFF >> (3'h3 - {1'b0, st.format[1:0]});
		// parity only when low code bit set
		par_on = st.format[2];
		// engines run only in serial mode
		run = st.trained && !st.debug_mode;
		bit_tick = 1'b0;
		rx_push = 1'b0;
		rx_data = st.rx_sh & len_mask;
		txq_pop = 1'b0;
		rxq_pop = 1'b0;
		req = (AVS_READ || AVS_WRITE) && !st.ack;
		wr = req && AVS_WRITE && AVS_BYTEENABLE[0];
		rd = req && AVS_READ;
		txq_push = 1'b0;
		per_set = 1'b0;
		fer_set = 1'b0;

		// ****************************************************
		// line input: sync, then filter
		// ****************************************************
		next_st.sync1 = SWIO_IN;
		next_st.sync2 = st.sync1;
		next_st.filt = {st.filt[1:0], st.sync2};
		next_st.line = (st.filt[0] & st.filt[1]) |
			(st.filt[1] & st.filt[2]) | (st.filt[0] & st.filt[2]);
		fall = st.line && !next_st.line;

		if (st.tick_cnt + 16'h0001 >= st.divisor) begin
			next_st.tick_cnt = 16'h0000;
			bit_tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 16'h0001;
		end

		// ****************************************************
		// training character measurement
		// ****************************************************
		// five falls of 0x55 span eight bit times
		if (!st.trained) begin
			if (st.falls != 3'h0) begin
				next_st.train_cnt = st.train_cnt + 16'h0001;
			end
			if (fall) begin
				next_st.falls = st.falls + 3'h1;
				if (st.falls == 3'h0) begin
					next_st.train_cnt = 16'h0001;
				end
				if (st.falls + 3'h1 == SWSU_TRAIN_FALLS) begin
					next_st.divisor = {3'h0, st.train_cnt[15:3]};
					next_st.trained = 1'b1;
					next_st.debug_mode =
						{3'h0, st.train_cnt[15:3]} <= SWSU_DEBUG_MAX_DIV;
					next_st.rx_state = SWSU_RX_WAIT_HIGH;
				end
			end
		end

		// ****************************************************
		// transmitter
		// ****************************************************
		if (st.tx_timer != 16'h0000) begin
			next_st.tx_timer = st.tx_timer - 16'h0001;
		end
		case (st.tx_state)
			SWSU_TX_IDLE: begin
				next_st.tx_oe = 1'b0;
				next_st.tx_line = 1'b1;
				// head moves in when shifter empty
				if (run && st.txq_cnt != 5'h00) begin
					txq_pop = 1'b1;
					next_st.tx_sh = st.txq[st.txq_rd];
					next_st.tx_state = SWSU_TX_START;
					next_st.tx_oe = 1'b1;
					// start bit low one bit time
					next_st.tx_line = 1'b0;
					next_st.tx_timer = st.divisor - 16'h0001;
					next_st.tx_bit = 3'h0;
				end
			end
			SWSU_TX_START, SWSU_TX_DATA, SWSU_TX_PAR: begin
				if (st.tx_timer == 16'h0000) begin
					next_st.tx_timer = st.divisor - 16'h0001;
					if (st.tx_state == SWSU_TX_START) begin
						next_st.tx_state = SWSU_TX_DATA;
						next_st.tx_line = st.tx_sh[0];
					end else if (st.tx_state == SWSU_TX_DATA &&
						st.tx_bit != last_bit) begin
						next_st.tx_bit = st.tx_bit + 3'h1;
						next_st.tx_line = st.tx_sh[st.tx_bit + 3'h1];
					end else if (st.tx_state == SWSU_TX_DATA && par_on) begin
						next_st.tx_state = SWSU_TX_PAR;
						next_st.tx_line = swsu_par(st.format[4:2],
							st.tx_sh & len_mask);
					end else begin
						// stop time one or two bits
						next_st.tx_state = SWSU_TX_STOP;
						next_st.tx_line = 1'b1;
						if (st.format[SWSU_FMT_STOP2]) begin
							next_st.tx_timer = {st.divisor[14:0], 1'b0} -
								16'h0001;
						end
					end
				end
			end
			SWSU_TX_STOP: begin
				if (st.tx_timer == 16'h0000) begin
					next_st.tx_state = SWSU_TX_IDLE;
					next_st.tx_oe = 1'b0;
					if (st.txq_cnt == 5'h00) begin
						next_st.tx_done = 1'b1;
					end
				end
			end
			default: next_st.tx_state = SWSU_TX_IDLE;
		endcase

		// ****************************************************
		// receiver
		// ****************************************************
		if (st.rx_timer != 16'h0000) begin
			next_st.rx_timer = st.rx_timer - 16'h0001;
		end
		case (st.rx_state)
			SWSU_RX_IDLE: begin
				if (run && fall && !(st.format[SWSU_FMT_ECHO] &&
					st.tx_oe)) begin
					next_st.rx_state = SWSU_RX_START;
					next_st.rx_timer = {1'b0, st.divisor[15:1]};
				end
			end
			SWSU_RX_START: begin
				if (st.rx_timer == 16'h0000) begin
					if (st.line) begin
						next_st.rx_state = SWSU_RX_IDLE;
					end else begin
						next_st.rx_state = SWSU_RX_DATA;
						next_st.rx_timer = st.divisor - 16'h0001;
						next_st.rx_bit = 3'h0;
						next_st.rx_sh = 8'h00;
					end
				end
			end
			SWSU_RX_DATA: begin
				if (st.rx_timer == 16'h0000) begin
					next_st.rx_sh[st.rx_bit] = st.line;
					next_st.rx_timer = st.divisor - 16'h0001;
					next_st.rx_bit = st.rx_bit + 3'h1;
					if (st.rx_bit == last_bit) begin
						next_st.rx_state = par_on ? SWSU_RX_PAR :
							SWSU_RX_STOP;
					end
				end
			end
			SWSU_RX_PAR: begin
				if (st.rx_timer == 16'h0000) begin
					next_st.rx_timer = st.divisor - 16'h0001;
					next_st.rx_state = SWSU_RX_STOP;
					if (st.line != swsu_par(st.format[4:2], rx_data)) begin
						per_set = 1'b1;
					end
				end
			end
			SWSU_RX_STOP: begin
				if (st.rx_timer == 16'h0000) begin
					if (!st.line) begin
						fer_set = 1'b1;
						next_st.rx_state = SWSU_RX_WAIT_HIGH;
					end else begin
						next_st.rx_state = SWSU_RX_IDLE;
						rx_push = !st.per && !next_st.per && !st.fer;
					end
				end
			end
			SWSU_RX_WAIT_HIGH: begin
				if (st.line) begin
					next_st.rx_state = SWSU_RX_IDLE;
				end
			end
			default: next_st.rx_state = SWSU_RX_IDLE;
		endcase

		// ****************************************************
		// register access
		// ****************************************************
		// threshold is code plus one
		tx_rdy = (SWSU_QUEUE_DEPTH - st.txq_cnt) >=
			({1'b0, st.tx_level} + 5'h01);
		rx_rdy = (st.rxq_cnt >= ({1'b0, st.rx_level} + 5'h01)) ||
			st.forced;
		status = {1'b0, st.per, st.fer, st.ovr, st.tx_done, rx_rdy, tx_rdy};
		next_st.ack = req;
		if (rd) begin
			next_st.rdata = SWSU_UNMAPPED_READ;
			if (AVS_ADDRESS == SWSU_OFF_TX_DATA) begin
				next_st.rdata[7:0] = st.tx_window;
			end else if (AVS_ADDRESS == SWSU_OFF_RX_DATA) begin
				next_st.rdata[7:0] = st.rxq[st.rxq_rd];
				rxq_pop = st.rxq_cnt != 5'h00;
			end else if (AVS_ADDRESS == SWSU_OFF_LINE_FORMAT) begin
				next_st.rdata[6:0] = st.format;
			end else if (AVS_ADDRESS == SWSU_OFF_LINE_STATUS) begin
				next_st.rdata[6:0] = status;
			end else if (AVS_ADDRESS == SWSU_OFF_IRQ_ENABLE) begin
				next_st.rdata[6:0] = st.irq_en;
			end else if (AVS_ADDRESS == SWSU_OFF_TXQ_STATUS) begin
				next_st.rdata[7:0] = {st.txq_cnt != SWSU_QUEUE_DEPTH,
					st.txq_cnt != 5'h00, 1'b0, st.txq_cnt};
			end else if (AVS_ADDRESS == SWSU_OFF_TXQ_CONTROL) begin
				next_st.rdata[3:0] = st.tx_level;
			end else if (AVS_ADDRESS == SWSU_OFF_RXQ_STATUS) begin
				next_st.rdata[7:0] = {st.rxq_cnt != SWSU_QUEUE_DEPTH,
					st.rxq_cnt != 5'h00, 1'b0, st.rxq_cnt};
			end else if (AVS_ADDRESS == SWSU_OFF_RXQ_CONTROL) begin
				next_st.rdata[3:0] = st.rx_level;
			end else if (AVS_ADDRESS == SWSU_OFF_IDLE_LOWER) begin
				next_st.rdata[7:0] = st.idle_limit[7:0];
			end else if (AVS_ADDRESS == SWSU_OFF_IDLE_UPPER) begin
				next_st.rdata[7:0] = st.idle_limit[15:8];
			end else if (AVS_ADDRESS == SWSU_OFF_DIV_LOWER) begin
				next_st.rdata[7:0] = st.divisor[7:0];
			end else if (AVS_ADDRESS == SWSU_OFF_DIV_UPPER) begin
				next_st.rdata[7:0] = st.divisor[15:8];
			end else if (AVS_ADDRESS == SWSU_OFF_MODE) begin
				next_st.rdata[1:0] = {st.trained, st.debug_mode};
			end
		end
		// hardware sets below win over software clears
		if (wr) begin
			if (AVS_ADDRESS == SWSU_OFF_TX_DATA) begin
				next_st.tx_window = AVS_WRITEDATA[7:0];
				txq_push = st.txq_cnt != SWSU_QUEUE_DEPTH;
			end else if (AVS_ADDRESS == SWSU_OFF_LINE_FORMAT) begin
				next_st.format = AVS_WRITEDATA[6:0];
			end else if (AVS_ADDRESS == SWSU_OFF_LINE_STATUS) begin
				next_st.tx_done = st.tx_done &
					!AVS_WRITEDATA[SWSU_ST_TX_DONE];
				next_st.ovr = st.ovr & !AVS_WRITEDATA[SWSU_ST_OVR];
				next_st.fer = st.fer & !AVS_WRITEDATA[SWSU_ST_FER];
				next_st.per = st.per & !AVS_WRITEDATA[SWSU_ST_PER];
			end else if (AVS_ADDRESS == SWSU_OFF_IRQ_ENABLE) begin
				next_st.irq_en = AVS_WRITEDATA[6:0];
			end else if (AVS_ADDRESS == SWSU_OFF_TXQ_CONTROL) begin
				next_st.tx_level = AVS_WRITEDATA[3:0];
			end else if (AVS_ADDRESS == SWSU_OFF_RXQ_CONTROL) begin
				next_st.rx_level = AVS_WRITEDATA[3:0];
			end else if (AVS_ADDRESS == SWSU_OFF_IDLE_LOWER) begin
				// low byte held until upper written
				next_st.idle_low = AVS_WRITEDATA[7:0];
			end else if (AVS_ADDRESS == SWSU_OFF_IDLE_UPPER) begin
				next_st.idle_limit = {AVS_WRITEDATA[7:0], st.idle_low};
			end else if (AVS_ADDRESS == SWSU_OFF_DIV_LOWER) begin
				next_st.div_low = AVS_WRITEDATA[7:0];
			end else if (AVS_ADDRESS == SWSU_OFF_DIV_UPPER) begin
				next_st.divisor = {AVS_WRITEDATA[7:0], st.div_low};
				next_st.debug_mode = {AVS_WRITEDATA[7:0], st.div_low} <=
					SWSU_DEBUG_MAX_DIV;
				next_st.trained = 1'b1;
				next_st.falls = 3'h0;
				next_st.tx_state = SWSU_TX_IDLE;
				next_st.tx_oe = 1'b0;
				next_st.tx_line = 1'b1;
				next_st.rx_state = SWSU_RX_WAIT_HIGH;
				next_st.tick_cnt = 16'h0000;
				txq_pop = 1'b0;
				rx_push = 1'b0;
			end
		end
		// error sets applied after the clear so the event is not lost
		if (per_set) begin
			next_st.per = 1'b1;
		end
		if (fer_set) begin
			next_st.fer = 1'b1;
		end
		if (st.tx_state != SWSU_TX_IDLE && next_st.tx_state ==
			SWSU_TX_IDLE && st.txq_cnt == 5'h00) begin
			next_st.tx_done = 1'b1;
		end else if (txq_push) begin
			next_st.tx_done = 1'b0;
		end

		// ****************************************************
		// queues
		// ****************************************************
		// transmit queue push and pop
		if (txq_push) begin
			next_st.txq[st.txq_wr] = AVS_WRITEDATA[7:0];
			next_st.txq_wr = st.txq_wr + 4'h1;
		end
		if (txq_pop) begin
			next_st.txq_rd = st.txq_rd + 4'h1;
		end
		next_st.txq_cnt = st.txq_cnt + {4'h0, txq_push} -
			{4'h0, txq_pop};
		if (rx_push && st.rxq_cnt == SWSU_QUEUE_DEPTH && !rxq_pop) begin
			next_st.ovr = 1'b1;
			rx_push = 1'b0;
		end
		if (rx_push) begin
			next_st.rxq[st.rxq_wr] = rx_data;
			next_st.rxq_wr = st.rxq_wr + 4'h1;
		end
		if (rxq_pop) begin
			next_st.rxq_rd = st.rxq_rd + 4'h1;
		end
		next_st.rxq_cnt = st.rxq_cnt + {4'h0, rx_push} -
			{4'h0, rxq_pop};
		if (wr && AVS_ADDRESS == SWSU_OFF_TXQ_CONTROL &&
			AVS_WRITEDATA[SWSU_QC_FLUSH]) begin
			next_st.txq_rd = 4'h0;
			next_st.txq_wr = 4'h0;
			next_st.txq_cnt = 5'h00;
		end
		if (wr && AVS_ADDRESS == SWSU_OFF_RXQ_CONTROL &&
			AVS_WRITEDATA[SWSU_QC_FLUSH]) begin
			next_st.rxq_rd = 4'h0;
			next_st.rxq_wr = 4'h0;
			next_st.rxq_cnt = 5'h00;
		end

		if (next_st.rxq_cnt == 5'h00) begin
			next_st.forced = 1'b0;
			next_st.idle_cnt = 17'h00000;
		end else if (rx_rdy || rx_push || rxq_pop) begin
			next_st.idle_cnt = 17'h00000;
		end else if (bit_tick) begin
			next_st.idle_cnt = st.idle_cnt + 17'h00001;
			if (st.idle_cnt + 17'h00001 >= {1'b0, st.idle_limit} +
				17'h00001) begin
				next_st.forced = 1'b1;
			end
		end
		next_st.irq = |(status & st.irq_en);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st <= '0;
			st.format <= SWSU_FORMAT_RST;
			st.divisor <= SWSU_DIV_RST;
			st.sync1 <= 1'b1;
			st.sync2 <= 1'b1;
			st.filt <= 3'h7;
			st.line <= 1'b1;
			st.tx_line <= 1'b1;
			st.tx_state <= SWSU_TX_IDLE;
			st.rx_state <= SWSU_RX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign AVS_READDATA = st.rdata;
	assign AVS_WAITREQUEST = !st.ack;
	assign SWIO_OUT = st.tx_line;
	assign SWIO_OE = st.tx_oe;
	assign IRQ = st.irq;
endmodule : swsu_unit
`default_nettype wire

// [swsu_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module swsu_chk (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic SWIO_OUT,
	input wire logic SWIO_OE,
	input wire logic IRQ
);
	// ****************************************************
	// bit and frame length counters
	// ****************************************************
	logic [15:0] gap;
	logic [15:0] run;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// serial mode needs divisor above 48, so a bit is 49+ cycles
	always_ff @(posedge CORE_CLK) begin
		gap <= (!SWIO_OE || $changed(SWIO_OUT)) ? 16'h0000 : gap + 16'h0001;
		run <= SWIO_OE ? run + 16'h0001 : 16'h0000;
	end
	a_quiet_reset: assert property ($fell(RST) |-> AVS_WAITREQUEST && !SWIO_OE && SWIO_OUT && !IRQ)
		else $error("outputs not quiet after reset");
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered next cycle");
	a_wait_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
		else $error("answer without request");
	a_start_low: assert property ($rose(SWIO_OE) |-> (SWIO_OE && !SWIO_OUT) [*8])
		else $error("frame does not open with low start");
	a_idle_high: assert property (!SWIO_OE |-> SWIO_OUT)
		else $error("line value low while released");
	a_stop_high: assert property ($fell(SWIO_OE) |-> $past(SWIO_OUT) && $past(SWIO_OUT, 8))
		else $error("frame not closed by high stop");
	a_bit_width: assert property (SWIO_OE && $past(SWIO_OE) && $changed(SWIO_OUT) |-> gap >= 16'h0030)
		else $error("bit shorter than serial bit time");
	a_frame_len: assert property ($fell(SWIO_OE) |-> run >= 16'h0157)
		else $error("frame shorter than seven bits");
	c_frame: cover property ($rose(SWIO_OE));
	c_read: cover property ($fell(AVS_WAITREQUEST) && AVS_READ);
	c_irq: cover property ($rose(IRQ));
endmodule : swsu_chk
bind swsu_unit swsu_chk swsu_chk_inst (.CORE_CLK(CORE_CLK), .RST(RST),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .SWIO_OUT(SWIO_OUT),
	.SWIO_OE(SWIO_OE), .IRQ(IRQ));
`default_nettype wire

// [swsu_host.sv]
`timescale 1ns/10ps
`default_nettype none
module swsu_host (
	input wire logic clk,
	input wire logic line,
	output var logic drv_oe,
	output var logic drv_val
);
	// ****************************************************
	// remote party on the shared line
	// ****************************************************
	initial begin
		drv_oe = 1'b0;
		drv_val = 1'b1;
	end
	function automatic logic par(input logic [7:0] d, input logic [6:0] f);
		logic [7:0] m;
		m = d & (8'hFF >> (3 - f[1:0]));
		case (f[4:2])
			3'h1: return ~^m;
			3'h3: return ^m;
			3'h5: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : par
	// lsb first; bad 1 flips parity, 2 low stop
	task automatic send(input logic [7:0] d, input int bt, input logic [6:0] f, input int bad);
		logic [11:0] b;
		int n;
		b = 12'hFFF;
		b[0] = 1'b0;
		n = 1;
		for (int i = 0; i < f[1:0] + 5; i++) begin
			b[n] = d[i];
			n = n + 1;
		end
		if (f[2]) begin
			b[n] = par(d, f) ^ (bad == 1);
			n = n + 1;
		end
		b[n] = (bad != 2);
		n = n + 1;
		// second stop already high in the preset
		if (f[5]) n = n + 1;
		@(posedge clk);
		for (int k = 0; k < n; k++) begin
			drv_oe <= 1'b1;
			drv_val <= b[k];
			repeat (bt) @(posedge clk);
		end
		// released line rises through the pull-up
		drv_oe <= 1'b0;
		drv_val <= 1'b1;
	endtask : send
	// both stops checked here, the unit checks only one
	task automatic capture(input int bt, input logic [6:0] f, output logic [7:0] d, output logic p, output logic ok);
		int t;
		d = 8'h00;
		p = 1'b0;
		for (t = 0; t < 400 && line; t++) @(negedge clk);
		repeat (bt / 2) @(negedge clk);
		ok = !line;
		for (int i = 0; i < f[1:0] + 5; i++) begin
			repeat (bt) @(negedge clk);
			d[i] = line;
		end
		if (f[2]) begin
			repeat (bt) @(negedge clk);
			p = line;
		end
		repeat (bt) @(negedge clk);
		ok &= line;
		if (f[5]) begin
			repeat (bt) @(negedge clk);
			ok &= line;
		end
	endtask : capture
endmodule : swsu_host
`default_nettype wire

// [swsu_unit_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module swsu_unit_tb_top;
	import swsu_pkg::*;
	// ****************************************************
	// bench signals and bus tasks
	// ****************************************************
	logic clk, rst, rd_en, wr_en, p, ok;
	logic [7:0] addr, d;
	logic [31:0] wdata, q;
	logic [3:0] be;
	wire logic [31:0] rdata;
	wire logic wreq, sw_out, sw_oe, irq, h_oe, h_val, line;
	int checks, failures;
	logic [6:0] fm[6] = '{7'h40, 7'h45, 7'h4E, 7'h77, 7'h5F, 7'h03};
	logic [7:0] dv[6] = '{8'h15, 8'h2A, 8'h5B, 8'hC3, 8'h81, 8'h3C};
	// pull-up line, either party may pull it low
	assign line = (sw_oe ? sw_out : 1'b1) & (h_oe ? h_val : 1'b1);
	always #4 clk = ~clk;
	swsu_unit swsu_unit_inst (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr),
		.AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.SWIO_IN(line), .SWIO_OUT(sw_out), .SWIO_OE(sw_oe), .IRQ(irq));
	swsu_host swsu_host_inst (.clk(clk), .line(line), .drv_oe(h_oe), .drv_val(h_val));
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [31:0] r);
		int t;
		addr <= a;
		wdata <= {24'h000000, v};
		rd_en <= !w;
		wr_en <= w;
		for (t = 0; t < 20; t++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		if (t == 20) begin
			failures++;
			$display("MISMATCH waitrequest expected 0 seen 1");
			finish_test();
		end else begin
			r = rdata;
			rd_en <= 1'b0;
			wr_en <= 1'b0;
			@(posedge clk);
		end
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		acc(1'b1, a, v, q);
	endtask : wr
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 8'h00, q);
		chk(n, e, q);
	endtask : rdc
	// ****************************************************
	// main sequence, bit time 50 cycles after setup
	// ****************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{rd_en, wr_en, addr, wdata} = '0;
		be = 4'hF;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc("format", SWSU_OFF_LINE_FORMAT, 8'h03);
		rdc("txq", SWSU_OFF_TXQ_STATUS, 8'h80);
		rdc("rxq", SWSU_OFF_RXQ_STATUS, 8'h80);
		rdc("unmapped", 8'h3C, 8'h00);
		swsu_host_inst.send(8'h55, 60, 7'h03, 0);
		repeat (20) @(posedge clk);
		rdc("div lo", SWSU_OFF_DIV_LOWER, 8'h3C);
		rdc("div hi", SWSU_OFF_DIV_UPPER, 8'h00);
		acc(1'b0, SWSU_OFF_MODE, 8'h00, q);
		chk("serial", 1'b0, q[0]);
		wr(SWSU_OFF_DIV_LOWER, 8'h30);
		wr(SWSU_OFF_DIV_UPPER, 8'h00);
		acc(1'b0, SWSU_OFF_MODE, 8'h00, q);
		chk("debug", 1'b1, q[0]);
		wr(SWSU_OFF_DIV_LOWER, 8'h32);
		wr(SWSU_OFF_DIV_UPPER, 8'h00);
		acc(1'b0, SWSU_OFF_MODE, 8'h00, q);
		chk("serial", 1'b0, q[0]);
		wr(SWSU_OFF_RXQ_CONTROL, 8'h80);
		rdc("rx flush", SWSU_OFF_RXQ_STATUS, 8'h80);
		// lane 0 disabled: the write must not land
		be <= 4'hE;
		wr(SWSU_OFF_IRQ_ENABLE, 8'h7F);
		be <= 4'hF;
		rdc("be ignored", SWSU_OFF_IRQ_ENABLE, 8'h00);
		$display("test setup done");
		for (int k = 0; k < 6; k++) begin
			wr(SWSU_OFF_LINE_FORMAT, {1'b0, fm[k]});
			wr(SWSU_OFF_TX_DATA, dv[k]);
			swsu_host_inst.capture(50, fm[k], d, p, ok);
			chk("tx stops", 1'b1, ok);
			chk("tx data", dv[k] & (8'hFF >> (3 - fm[k][1:0])), d);
			chk("tx par", swsu_host_inst.par(dv[k], fm[k]), p);
			repeat (100) @(posedge clk);
			swsu_host_inst.send(~dv[k], 50, fm[k], 0);
			rdc("rx count", SWSU_OFF_RXQ_STATUS, fm[k][6] ? 8'hC1 : 8'hC2);
			if (!fm[k][6]) rdc("echo", SWSU_OFF_RX_DATA, dv[k]);
			rdc("rx data", SWSU_OFF_RX_DATA, ~dv[k] & (8'hFF >> (3 - fm[k][1:0])));
		end
		$display("test formats done");
		wr(SWSU_OFF_LINE_FORMAT, 8'h07);
		swsu_host_inst.send(8'h11, 50, 7'h07, 1);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("par err", 1'b1, q[SWSU_ST_PER]);
		rdc("rxq", SWSU_OFF_RXQ_STATUS, 8'h80);
		wr(SWSU_OFF_LINE_STATUS, 8'h20);
		swsu_host_inst.send(8'h11, 50, 7'h07, 2);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("frm err", 1'b1, q[SWSU_ST_FER]);
		wr(SWSU_OFF_LINE_STATUS, 8'h10);
		swsu_host_inst.send(8'h11, 50, 7'h07, 0);
		rdc("rxq", SWSU_OFF_RXQ_STATUS, 8'hC1);
		rdc("rx", SWSU_OFF_RX_DATA, 8'h11);
		acc(1'b0, SWSU_OFF_RX_DATA, 8'h00, q);
		rdc("rx empty", SWSU_OFF_RXQ_STATUS, 8'h80);
		$display("test errors done");
		wr(SWSU_OFF_RXQ_CONTROL, 8'h01);
		wr(SWSU_OFF_IDLE_LOWER, 8'h03);
		wr(SWSU_OFF_IDLE_UPPER, 8'h00);
		wr(SWSU_OFF_LINE_FORMAT, 8'h03);
		swsu_host_inst.send(8'h5A, 50, 7'h03, 0);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("rx flag", 1'b0, q[SWSU_ST_RX_RDY]);
		repeat (300) @(posedge clk);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("rx forced", 1'b1, q[SWSU_ST_RX_RDY]);
		rdc("rx", SWSU_OFF_RX_DATA, 8'h5A);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("rx flag", 1'b0, q[SWSU_ST_RX_RDY]);
		$display("test timeout done");
		wr(SWSU_OFF_LINE_FORMAT, 8'h43);
		wr(SWSU_OFF_TXQ_CONTROL, 8'h0F);
		wr(SWSU_OFF_IRQ_ENABLE, 8'h01);
		for (int i = 0; i < 18; i++) wr(SWSU_OFF_TX_DATA, i[7:0]);
		rdc("txq full", SWSU_OFF_TXQ_STATUS, 8'h50);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("tx space", 1'b0, q[SWSU_ST_TX_RDY]);
		chk("irq", 1'b0, irq);
		rdc("tx win", SWSU_OFF_TX_DATA, 8'h11);
		wr(SWSU_OFF_TXQ_CONTROL, 8'h80);
		rdc("tx flush", SWSU_OFF_TXQ_STATUS, 8'h80);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("tx space", 1'b1, q[SWSU_ST_TX_RDY]);
		chk("irq", 1'b1, irq);
		wr(SWSU_OFF_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge clk);
		chk("irq", 1'b0, irq);
		repeat (700) @(posedge clk);
		chk("line idle", 1'b0, sw_oe);
		rdc("txq", SWSU_OFF_TXQ_STATUS, 8'h80);
		$display("test tx queue done");
		wr(SWSU_OFF_LINE_FORMAT, 8'h03);
		for (int i = 0; i < 17; i++) swsu_host_inst.send(i[7:0], 50, 7'h03, 0);
		acc(1'b0, SWSU_OFF_LINE_STATUS, 8'h00, q);
		chk("overrun", 1'b1, q[SWSU_ST_OVR]);
		rdc("rxq full", SWSU_OFF_RXQ_STATUS, 8'h50);
		$display("test overrun done");
		finish_test();
	end
endmodule : swsu_unit_tb_top
`default_nettype wire
